// ### design/cls_exec.sv
// execution unit for short invert/or/byte store/breakpoint and multi store
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - invert minor 0 in short logic group writes complement of source to target
// - short selectors other than byte store data reach only registers 2-7, 16 and 17
// - or minor 9 writes source OR target back into target
// - short byte store writes low target byte at base plus unsigned offset
// - byte store base maps as usual; data selector maps to 0,2-7,17
// - byte store passes refill, invalid, modified, bus, address, watch faults
// - short breakpoint raises debug exception to the debug handler
// - breakpoint in debug mode raises debug-mode exception, cause 0x9
// - breakpoint code field is ignored; handler reads it via return address
// - multi store: major 001000, minor 1111, list, base, signed 12-bit offset
// - list low bits count 0-9 from 16..23,30; top bit adds 31
// - each listed register is stored as a full 64-bit doubleword
// - stores go leftmost first, address plus 8 each, each translated alone
// - interrupt masking during multi store is a software-chosen control bit
// - without release 6, misaligned multi store start raises address error
// - with release 6, misaligned start is passed on to memory unchanged
// - any fault mid-sequence abandons it; re-execution restarts at first register
module cls_exec
  import cls_pkg::*;
#(
  parameter int XLEN = 64
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  input  wire logic        INSTR_VALID_I,
  input  wire logic        INSTR_WIDE_I,
  input  wire logic [31:0] INSTR_I,
  input  wire logic [63:0] INSTR_PC_I,
  output logic             INSTR_READY_O,
  output logic             INSTR_DONE_O,
  input  wire logic        DEBUG_MODE_I,
  output logic       [4:0] RF_RA_ADDR_O,
  input  wire logic [63:0] RF_RA_DATA_I,
  output logic       [4:0] RF_RB_ADDR_O,
  input  wire logic [63:0] RF_RB_DATA_I,
  output logic             RF_WE_O,
  output logic       [4:0] RF_WADDR_O,
  output logic      [63:0] RF_WDATA_O,
  output logic             ST_REQ_O,
  output logic      [63:0] ST_ADDR_O,
  output logic      [63:0] ST_DATA_O,
  output logic             ST_DW_O,
  input  wire logic        ST_ACK_I,
  input  wire logic        ST_FAULT_I,
  input  wire logic  [3:0] ST_FAULT_CODE_I,
  output logic             EXC_VALID_O,
  output logic       [3:0] EXC_CODE_O,
  output logic      [63:0] EXC_PC_O,
  output logic       [4:0] DEBUG_CAUSE_O,
  output logic             CORE_INT_MASK_O,
  input  wire logic  [7:0] BUS_ADDR_I,
  input  wire logic [31:0] BUS_WDATA_I,
  input  wire logic        BUS_WE_I,
  input  wire logic        BUS_RE_I,
  output logic      [31:0] BUS_RDATA_O,
  output logic             IRQ_O
);
  // ==================================================
  // elaboration check
  if (XLEN != 64) begin : g_bad_xlen
    $error("cls_exec supports only a 64-bit datapath");
  end

  state_e      state_r;
  logic [3:0]  idx_r;
  logic [4:0]  list_r;
  logic [63:0] ms_addr_r;
  logic [63:0] pc_r;
  logic        st_req_r;
  logic [63:0] st_addr_r;
  logic [63:0] st_data_r;
  logic        st_dw_r;
  logic        we_r;
  logic [4:0]  waddr_r;
  logic [63:0] wdata_r;
  logic        done_r;
  logic        exc_v_r;
  exc_e        exc_code_r;
  logic [63:0] exc_pc_r;
  logic [4:0]  dcause_r;
  logic [4:0]  status_r;
  logic [4:0]  enable_r;
  logic [2:0]  ctrl_r;
  logic [31:0] rdata_r;

  // ==================================================
  // decode
  logic        acc;
  logic        is_logic;
  logic        is_inv;
  logic        is_or;
  logic        is_brk;
  logic        is_sb;
  logic        is_sdm;
  logic        is_unk;
  logic [4:0]  src_g;
  logic [4:0]  tgt_g;
  logic [4:0]  dat_g;
  logic [4:0]  list_g;
  logic [3:0]  list_last;
  logic        list_ok;
  logic [4:0]  dec_list;
  logic [3:0]  dec_idx;
  logic [63:0] sdm_start;
  logic        sdm_mis;
  logic        sdm_go;
  logic        sdm_ri;
  logic        at_last;
  logic        ack;
  logic        flt;

  assign acc      = INSTR_VALID_I && (state_r == ST_IDLE);
  assign is_logic = !INSTR_WIDE_I && (INSTR_I[P_MAJ16 +: 6] == OP_LOGIC);
  assign is_inv   = is_logic && (INSTR_I[P_MIN16 +: 4] == MIN_INV);
  assign is_or    = is_logic && (INSTR_I[P_MIN16 +: 4] == MIN_OR);
  assign is_brk   = is_logic && (INSTR_I[P_MIN16 +: 4] == MIN_BRK);
  assign is_sb    = !INSTR_WIDE_I && (INSTR_I[P_MAJ16 +: 6] == OP_SBYTE);
  assign is_sdm   = INSTR_WIDE_I && (INSTR_I[P_MAJ32 +: 6] == OP_WIDE)
                    && (INSTR_I[P_MIN32 +: 4] == MIN_SDM);
  assign is_unk   = !(is_inv || is_or || is_brk || is_sb || is_sdm);

  short_reg_map u_src_map (
    .SEL_I       (INSTR_I[P_SRC +: 3]),
    .DATA_FORM_I (1'b0),
    .GPR_O       (src_g)
  );
  short_reg_map u_tgt_map (
    .SEL_I       (INSTR_I[P_TGT +: 3]),
    .DATA_FORM_I (1'b0),
    .GPR_O       (tgt_g)
  );
  short_reg_map u_dat_map (
    .SEL_I       (INSTR_I[P_TGT +: 3]),
    .DATA_FORM_I (1'b1),
    .GPR_O       (dat_g)
  );

  // list is latched at start so the fetch stream may move on
  assign dec_list = (state_r == ST_MULTI) ? list_r : INSTR_I[P_LIST +: 5];
  assign dec_idx  = (state_r == ST_MULTI) ? idx_r : 4'h0;
  reglist_decoder u_list (
    .LIST_I (dec_list),
    .IDX_I  (dec_idx),
    .GPR_O  (list_g),
    .LAST_O (list_last),
    .OK_O   (list_ok)
  );

  // ==================================================
  // register read selection
  always_comb begin
    if (state_r == ST_MULTI) begin
      RF_RA_ADDR_O = list_g;
    end else if (is_sdm) begin
      RF_RA_ADDR_O = INSTR_I[P_BASE +: 5];
    end else begin
      RF_RA_ADDR_O = src_g;
    end
    RF_RB_ADDR_O = is_sb ? dat_g : tgt_g;
  end

  assign sdm_start = RF_RA_DATA_I
                     + {{52{INSTR_I[P_OFF + 11]}}, INSTR_I[P_OFF +: 12]};
  // release 6 leaves low address bits to the memory system
  assign sdm_mis = !ctrl_r[C_REL6] && (sdm_start[2:0] != 3'h0);
  // reserved list codes are refused like any unknown encoding
  assign sdm_ri  = !ctrl_r[C_OP64] || !list_ok;
  assign sdm_go  = acc && is_sdm && !sdm_ri && !sdm_mis;
  assign at_last = (idx_r == list_last);
  assign ack     = st_req_r && ST_ACK_I && !ST_FAULT_I;
  assign flt     = st_req_r && ST_FAULT_I;

  // ==================================================
  // sequencer
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (acc && is_sb) begin
            state_r <= ST_BYTE;
          end else if (sdm_go) begin
            state_r <= ST_MULTI;
          end
        end
        ST_BYTE: begin
          if (ack || flt) begin
            state_r <= ST_IDLE;
          end
        end
        ST_MULTI: begin
          if (flt || (ack && at_last)) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      idx_r     <= 4'h0;
      list_r    <= 5'h00;
      ms_addr_r <= 64'h0;
      pc_r      <= 64'h0;
    end else if (acc) begin
      idx_r     <= 4'h0;
      list_r    <= INSTR_I[P_LIST +: 5];
      ms_addr_r <= sdm_start;
      pc_r      <= INSTR_PC_I;
    end else if ((state_r == ST_MULTI) && ack) begin
      idx_r     <= idx_r + 4'h1;
      ms_addr_r <= ms_addr_r + DW_STEP;
    end
  end

  // ==================================================
  // store port
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      st_req_r  <= 1'b0;
      st_addr_r <= 64'h0;
      st_data_r <= 64'h0;
      st_dw_r   <= 1'b0;
    end else if (acc && is_sb) begin
      st_req_r  <= 1'b1;
      st_addr_r <= RF_RA_DATA_I + {60'h0, INSTR_I[P_OFF +: 4]};
      st_data_r <= {56'h0, RF_RB_DATA_I[7:0]};
      st_dw_r   <= 1'b0;
    end else if ((state_r == ST_MULTI) && !st_req_r) begin
      // one request per register so each address is translated on its own
      st_req_r  <= 1'b1;
      st_addr_r <= ms_addr_r;
      st_data_r <= RF_RA_DATA_I;
      st_dw_r   <= 1'b1;
    end else if (ack || flt) begin
      st_req_r  <= 1'b0;
    end
  end

  assign ST_REQ_O  = st_req_r;
  assign ST_ADDR_O = st_addr_r;
  assign ST_DATA_O = st_data_r;
  assign ST_DW_O   = st_dw_r;

  // ==================================================
  // register write-back
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      we_r    <= 1'b0;
      waddr_r <= 5'h00;
      wdata_r <= 64'h0;
    end else begin
      we_r <= acc && (is_inv || is_or);
      if (acc && (is_inv || is_or)) begin
        waddr_r <= tgt_g;
        wdata_r <= is_inv ? ~RF_RA_DATA_I : (RF_RA_DATA_I | RF_RB_DATA_I);
      end
    end
  end

  assign RF_WE_O    = we_r;
  assign RF_WADDR_O = waddr_r;
  assign RF_WDATA_O = wdata_r;

  // ==================================================
  // exceptions and retirement
  function automatic exc_e fault_map(input logic [3:0] c);
    unique case (c)
      4'h0: fault_map = EXC_REFILL;
      4'h1: fault_map = EXC_INVAL;
      4'h2: fault_map = EXC_MOD;
      4'h3: fault_map = EXC_BUS;
      4'h4: fault_map = EXC_ADDR;
      default: fault_map = EXC_WATCH;
    endcase
  endfunction : fault_map

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      exc_v_r    <= 1'b0;
      exc_code_r <= EXC_NONE;
      exc_pc_r   <= 64'h0;
      dcause_r   <= 5'h00;
      done_r     <= 1'b0;
    end else begin
      exc_v_r <= 1'b0;
      done_r  <= (acc && (is_inv || is_or))
                 || (ack && ((state_r == ST_BYTE) || at_last));
      if (flt) begin
        exc_v_r    <= 1'b1;
        exc_code_r <= fault_map(ST_FAULT_CODE_I);
        exc_pc_r   <= pc_r;
      end else if (acc && (is_brk || is_unk || (is_sdm && !sdm_go))) begin
        exc_v_r  <= 1'b1;
        exc_pc_r <= INSTR_PC_I;
        if (is_brk) begin
          // code field bits never steer anything here
          exc_code_r <= DEBUG_MODE_I ? EXC_DBG_MODE_BP : EXC_DBG_BP;
          if (DEBUG_MODE_I) begin
            dcause_r <= CAUSE_BP;
          end
        end else if (is_sdm && !sdm_ri) begin
          exc_code_r <= EXC_ADDR;
        end else begin
          exc_code_r <= EXC_RI;
        end
      end
    end
  end

  assign INSTR_READY_O = (state_r == ST_IDLE);
  assign INSTR_DONE_O  = done_r;
  assign EXC_VALID_O   = exc_v_r;
  assign EXC_CODE_O    = exc_code_r;
  assign EXC_PC_O      = exc_pc_r;
  assign DEBUG_CAUSE_O = dcause_r;
  assign CORE_INT_MASK_O = (state_r == ST_MULTI) && ctrl_r[C_MASK];

  // ==================================================
  // events and register bus
  logic [4:0] ev;
  always_comb begin
    ev         = 5'h00;
    ev[E_BRK]  = exc_v_r && (exc_code_r inside {EXC_DBG_BP, EXC_DBG_MODE_BP});
    ev[E_ADDR] = exc_v_r && (exc_code_r == EXC_ADDR);
    ev[E_RI]   = exc_v_r && (exc_code_r == EXC_RI);
    ev[E_FLT]  = exc_v_r && (exc_code_r inside {[EXC_REFILL:EXC_WATCH]});
    ev[E_DONE] = done_r && (state_r == ST_IDLE) && st_dw_r && !we_r; // dw flag is stale after logic ops
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      status_r <= 5'h00;
    end else if (BUS_WE_I && (BUS_ADDR_I == A_CLEAR)) begin
      // a new event in the clearing cycle survives
      status_r <= (status_r & ~BUS_WDATA_I[4:0]) | ev;
    end else begin
      status_r <= status_r | ev;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      enable_r <= EN_RST;
      ctrl_r   <= CTRL_RST;
    end else if (BUS_WE_I) begin
      if (BUS_ADDR_I == A_ENABLE) begin
        enable_r <= BUS_WDATA_I[4:0];
      end
      if (BUS_ADDR_I == A_CTRL) begin
        ctrl_r <= BUS_WDATA_I[2:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rdata_r <= 32'h0;
    end else if (BUS_RE_I) begin
      unique case (BUS_ADDR_I)
        A_STATUS: rdata_r <= {27'h0, status_r};
        A_ENABLE: rdata_r <= {27'h0, enable_r};
        A_CTRL:   rdata_r <= {29'h0, ctrl_r};
        A_STATE:  rdata_r <= {22'h0, idx_r, exc_code_r, state_r};
        default:  rdata_r <= 32'h0;
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign BUS_RDATA_O = rdata_r;
  assign IRQ_O       = |(status_r & enable_r);

  // ==================================================
  // checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  invert_result_a: assert property (
    acc && is_inv |=> RF_WE_O && (RF_WDATA_O == ~$past(RF_RA_DATA_I)))
    else $error("invert result wrong");
  or_result_a: assert property (
    acc && is_or |=> RF_WE_O && (RF_WDATA_O == ($past(RF_RA_DATA_I) | $past(RF_RB_DATA_I))))
    else $error("or result wrong");
  target_sel_range_a: assert property (
    RF_WE_O |-> (RF_WADDR_O inside {[5'h02:5'h07], 5'h10, 5'h11}))
    else $error("short target outside permitted set");
  byte_store_data_a: assert property (
    acc && is_sb |=> ST_REQ_O && !ST_DW_O && (ST_DATA_O[7:0] == $past(RF_RB_DATA_I[7:0]))
    && (ST_DATA_O[63:8] == 56'h0))
    else $error("byte store data wrong");
  brk_debug_mode_a: assert property (
    acc && is_brk && DEBUG_MODE_I |=> EXC_VALID_O && (EXC_CODE_O == EXC_DBG_MODE_BP)
    && (DEBUG_CAUSE_O == 5'h09))
    else $error("debug mode breakpoint cause wrong");
  brk_normal_a: assert property (
    acc && is_brk && !DEBUG_MODE_I |=> EXC_VALID_O && (EXC_CODE_O == EXC_DBG_BP) && !RF_WE_O)
    else $error("breakpoint did not raise debug exception");
  multi_step_a: assert property (
    (state_r == ST_MULTI) && ack && !at_last |-> ##2 ST_REQ_O && (ST_ADDR_O == $past(ST_ADDR_O, 2) + 64'h8))
    else $error("multi store address step wrong");
  multi_dword_a: assert property (
    (state_r == ST_MULTI) && ST_REQ_O |-> ST_DW_O)
    else $error("multi store not doubleword");
  ri_no_store_a: assert property (
    acc && is_sdm && !ctrl_r[C_OP64] |=> !ST_REQ_O && EXC_VALID_O && (EXC_CODE_O == EXC_RI)
    ##1 !ST_REQ_O)
    else $error("multi store ran with 64-bit ops off");
  misalign_fault_a: assert property (
    acc && is_sdm && !sdm_ri && !ctrl_r[C_REL6] && (sdm_start[2:0] != 3'h0)
    |=> EXC_VALID_O && (EXC_CODE_O == EXC_ADDR) && (state_r == ST_IDLE))
    else $error("misaligned multi store not faulted");
endmodule : cls_exec
`default_nettype wire

// ### design/cls_pkg.sv
// shared constants and types for the compact logic/store execution block
package cls_pkg;
  // ==================================================
  // opcodes and minor codes
  localparam logic [5:0] OP_LOGIC = 6'h11;
  localparam logic [5:0] OP_SBYTE = 6'h22;
  localparam logic [5:0] OP_WIDE  = 6'h08;
  localparam logic [3:0] MIN_INV  = 4'h0;
  localparam logic [3:0] MIN_OR   = 4'h9;
  localparam logic [3:0] MIN_BRK  = 4'hB;
  localparam logic [3:0] MIN_SDM  = 4'hF;
  // ==================================================
  // field positions
  localparam int P_MAJ16 = 10;
  localparam int P_TGT   = 7;
  localparam int P_SRC   = 4;
  localparam int P_MIN16 = 0;
  localparam int P_MAJ32 = 26;
  localparam int P_LIST  = 21;
  localparam int P_BASE  = 16;
  localparam int P_MIN32 = 12;
  localparam int P_OFF   = 0;
  // ==================================================
  // sequence constants
  localparam logic [63:0] DW_STEP  = 64'h8;
  localparam logic [4:0]  CAUSE_BP = 5'h09;
  localparam logic [3:0]  LIST_MAX = 4'h9;
  // ==================================================
  // register map
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CLEAR  = 8'h04;
  localparam logic [7:0] A_ENABLE = 8'h08;
  localparam logic [7:0] A_CTRL   = 8'h0C;
  localparam logic [7:0] A_STATE  = 8'h10;
  localparam int C_REL6 = 0;
  localparam int C_OP64 = 1;
  localparam int C_MASK = 2;
  localparam logic [2:0] CTRL_RST = 3'h7;
  localparam logic [4:0] EN_RST   = 5'h00;
  localparam int E_BRK  = 0;
  localparam int E_ADDR = 1;
  localparam int E_RI   = 2;
  localparam int E_FLT  = 3;
  localparam int E_DONE = 4;
  // ==================================================
  // enumerations
  typedef enum logic [3:0] {
    EXC_NONE = 4'h0, EXC_ADDR = 4'h1, EXC_RI = 4'h2,
    EXC_REFILL = 4'h3, EXC_INVAL = 4'h4, EXC_MOD = 4'h5,
    EXC_BUS = 4'h6, EXC_WATCH = 4'h7,
    EXC_DBG_BP = 4'h8, EXC_DBG_MODE_BP = 4'h9
  } exc_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_BYTE = 2'b01, ST_MULTI = 2'b10
  } state_e;
endpackage : cls_pkg

// ### design/reglist_decoder.sv
// decodes the multi-store register list into last slot index and per-slot register
`timescale 1ns/1ps
`default_nettype none
module reglist_decoder
  import cls_pkg::*;
(
  input  wire logic [4:0] LIST_I,
  input  wire logic [3:0] IDX_I,
  output logic      [4:0] GPR_O,
  output logic      [3:0] LAST_O,
  output logic            OK_O
);
  logic [3:0] n;
  logic       top;
  assign n   = LIST_I[3:0];
  assign top = LIST_I[4];
  // ==================================================
  // validity and length
  assign OK_O   = (n <= LIST_MAX) && ((n != 4'h0) || top);
  assign LAST_O = n + {3'h0, top} - 4'h1;
  // ==================================================
  // slot to register, leftmost first
  always_comb begin
    if (IDX_I < n) begin
      GPR_O = (IDX_I < 4'h8) ? (5'h10 + {1'b0, IDX_I}) : 5'h1E;
    end else begin
      GPR_O = 5'h1F;
    end
  end
endmodule : reglist_decoder
`default_nettype wire

// ### design/short_reg_map.sv
// maps a 3-bit short-form selector onto a general register number
`timescale 1ns/1ps
`default_nettype none
module short_reg_map (
  input  wire logic [2:0] SEL_I,
  input  wire logic       DATA_FORM_I,
  output logic      [4:0] GPR_O
);
  // ==================================================
  // decode
  always_comb begin
    unique case (SEL_I)
      3'h0: GPR_O = DATA_FORM_I ? 5'h00 : 5'h10;
      3'h1: GPR_O = 5'h11;
      default: GPR_O = {2'h0, SEL_I};
    endcase
  end
endmodule : short_reg_map
`default_nettype wire

// ### verif/compact_logic_store_exec_test.sv
// self-checking bench for the compact logic/store execution block
`timescale 1ns/1ps
`default_nettype none
module compact_logic_store_exec_test;
  import cls_pkg::*;
  typedef struct packed {logic [63:0] a; logic [63:0] d; logic dw; logic m;} st_s;
  // ======
  // signals
  logic        clk = 1'b0, rst_n = 1'b0, valid = 1'b0, wide = 1'b0, dbg = 1'b0;
  logic        bwe = 1'b0, bre = 1'b0;
  logic [31:0] instr = 32'h0, wdat = 32'h0, seed = 32'h48, rdata;
  logic [63:0] pc = 64'h0, pcv, wd_c, epc_c, wd, sa, sd, epc, gpr[32];
  logic [7:0]  badr = 8'h00;
  logic [3:0]  dly = 4'h0, fcode = 4'h0, exc, exc_c, fc;
  logic [15:0] fault_at = 16'hFFFF, n_st;
  logic [4:0]  ra, rb, wa, wa_c, dcause;
  logic [2:0]  ctrl = 3'h7;
  logic        ready, done, we, sreq, sdw, ack, flt, exv, imask, irq;
  int          ev, nev, n_mismatch, n_checks;
  st_s         sq[$];

  cls_exec dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(valid), .INSTR_WIDE_I(wide), .INSTR_I(instr),
    .INSTR_PC_I(pc), .INSTR_READY_O(ready), .INSTR_DONE_O(done), .DEBUG_MODE_I(dbg),
    .RF_RA_ADDR_O(ra), .RF_RA_DATA_I(gpr[ra]), .RF_RB_ADDR_O(rb), .RF_RB_DATA_I(gpr[rb]),
    .RF_WE_O(we), .RF_WADDR_O(wa), .RF_WDATA_O(wd), .ST_REQ_O(sreq), .ST_ADDR_O(sa), .ST_DATA_O(sd),
    .ST_DW_O(sdw), .ST_ACK_I(ack), .ST_FAULT_I(flt), .ST_FAULT_CODE_I(fc), .EXC_VALID_O(exv),
    .EXC_CODE_O(exc), .EXC_PC_O(epc), .DEBUG_CAUSE_O(dcause), .CORE_INT_MASK_O(imask),
    .BUS_ADDR_I(badr), .BUS_WDATA_I(wdat), .BUS_WE_I(bwe), .BUS_RE_I(bre), .BUS_RDATA_O(rdata),
    .IRQ_O(irq));
  store_partner far_end (
    .CLK_I(clk), .RST_N_I(rst_n), .REQ_I(sreq), .DELAY_I(dly), .FAULT_AT_I(fault_at),
    .FCODE_I(fcode), .ACK_O(ack), .FAULT_O(flt), .CODE_O(fc), .N_O(n_st));

  always #5 clk = ~clk;

  // sampling on the falling edge keeps it clear of the launch edge
  always @(negedge clk) begin
    if (sreq && ack) sq.push_back('{sa, sd, sdw, imask});
    if (we) begin
      wa_c = wa;
      wd_c = wd;
    end
    if (done) begin
      ev = 1;
      nev++;
    end
    if (exv) begin
      ev = 2;
      exc_c = exc;
      epc_c = epc;
      nev++;
    end
  end

  // ======
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [4:0] m3(input logic [2:0] s, input logic d);
    return (s == 3'h0) ? (d ? 5'h00 : 5'h10) : (s == 3'h1) ? 5'h11 : {2'h0, s};
  endfunction : m3

  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bwe <= 1'b1;
    badr <= a;
    wdat <= d;
    @(posedge clk);
    bwe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bre <= 1'b1;
    badr <= a;
    @(posedge clk);
    bre <= 1'b0;
    @(negedge clk);
    cmp(rdata, e);
  endtask : rd

  task automatic run(input logic w, input logic [31:0] i);
    int k, k0;
    k0 = nev;
    ev = 0;
    pcv = {rnd(), rnd()};
    sq.delete();
    wa_c = 5'h00;
    exc_c = 4'h0;
    @(posedge clk);
    valid <= 1'b1;
    wide <= w;
    instr <= i;
    pc <= pcv;
    dly <= 4'(rnd() & 32'h3);
    @(posedge clk);
    valid <= 1'b0;
    for (k = 0; k < 400 && nev == k0; k++) @(posedge clk);
    if (k == 400) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : run

  task automatic store_doubleword_multiple(input logic [4:0] l, input logic [11:0] off, input int fk);
    logic [4:0]  b;
    logic [63:0] st;
    int          r[$];
    int          ex, cnt;
    b = 5'(rnd());
    if (b != 5'h00) gpr[b][2:0] = 3'h0;
    st = gpr[b] + {{52{off[11]}}, off};
    for (int i = 0; i < l[3:0]; i++) r.push_back(i < 8 ? 16 + i : 30);
    if (l[4]) r.push_back(31);
    ex = (l[3:0] > 9 || r.size() == 0 || !ctrl[1]) ? 2 : (!ctrl[0] && st[2:0] != 3'h0) ? 1 : 0;
    wr(A_CLEAR, 32'h1F);
    fcode <= 4'h3;
    fault_at <= (fk < 0) ? 16'hFFFF : n_st + 16'(fk);
    run(1'b1, {OP_WIDE, l, b, MIN_SDM, off});
    if (ex == 0 && fk >= 0) ex = 6;
    cnt = (ex == 6) ? fk : (ex != 0) ? 0 : r.size();
    cmp(ev, (ex != 0) ? 2 : 1);
    if (ex != 0) cmp(exc_c, ex);
    cmp(sq.size(), cnt);
    for (int i = 0; i < cnt; i++) begin
      cmp(sq[i].a, st + 64'(8 * i));
      cmp(sq[i].d, gpr[r[i]]);
      cmp(sq[i].dw, 1);
      cmp(sq[i].m, ctrl[2]);
    end
    rd(A_STATUS, (ex == 0) ? 32'h10 : (ex == 6) ? 32'h8 : 32'(ex << 1));
    fault_at <= 16'hFFFF;
  endtask : store_doubleword_multiple

  // ======
  // sequence
  initial begin
    logic [63:0] x;
    logic [3:0]  off;
    logic [2:0]  t, s;
    logic [3:0]  fmap[6];
    logic [2:0]  cv[4];
    fmap = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h1, 4'h7};
    cv = '{3'h6, 3'h5, 3'h3, 3'h7};
    for (int i = 0; i < 32; i++) gpr[i] = (i == 0) ? 64'h0 : {rnd(), rnd()};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp(ready, 1);
    cmp(exc, 0);
    rd(A_STATUS, 0);
    rd(A_ENABLE, 0);
    rd(A_CTRL, 32'h7);
    for (int i = 0; i < 128; i++) begin
      t = i[2:0];
      s = i[5:3];
      x = i[6] ? (gpr[m3(s, 0)] | gpr[m3(t, 0)]) : ~gpr[m3(s, 0)];
      run(1'b0, {16'(rnd()), OP_LOGIC, t, s, i[6] ? MIN_OR : MIN_INV});
      cmp(ev, 1);
      cmp(wa_c, m3(t, 0));
      cmp(wd_c, x);
      gpr[m3(t, 0)] = x;
    end
    for (int i = 0; i < 14; i++) begin
      t = 3'(rnd());
      s = i[2:0];
      off = i[0] ? 4'hF : 4'h0;
      fcode <= 4'(i - 8);
      fault_at <= (i > 7) ? n_st : 16'hFFFF;
      x = gpr[m3(s, 0)] + 64'(off);
      run(1'b0, {16'(rnd()), OP_SBYTE, t, s, off});
      if (i > 7) begin
        cmp(exc_c, fmap[i - 8]);
        cmp(epc_c, pcv);
      end else begin
        cmp(sq[0].a, x);
        cmp(sq[0].d, {56'h0, gpr[m3(t, 1)][7:0]});
        cmp(sq[0].dw, 0);
      end
    end
    fault_at <= 16'hFFFF;
    for (int i = 0; i < 4; i++) begin
      dbg <= i[1];
      run(1'b0, {16'(rnd()), OP_LOGIC, 6'(rnd()), MIN_BRK});
      cmp(exc_c, i[1] ? 4'h9 : 4'h8);
      cmp(epc_c, pcv);
      if (i[1]) cmp(dcause, CAUSE_BP);
    end
    dbg <= 1'b0;
    run(1'b0, {16'h0, OP_LOGIC, 6'h12, 4'h5});
    cmp(ev, 2);
    cmp(exc_c, 4'h2);
    run(1'b1, {OP_WIDE, 5'h02, 5'h03, 4'hC, 12'h000});
    cmp(ev, 2);
    cmp(exc_c, 4'h2);
    for (int l = 0; l < 32; l++) store_doubleword_multiple(5'(l), 12'(rnd()), -1);
    store_doubleword_multiple(5'h03, 12'h010, 1);
    store_doubleword_multiple(5'h03, 12'h010, -1);
    for (int i = 0; i < 4; i++) begin
      ctrl = cv[i];
      wr(A_CTRL, 32'(ctrl));
      rd(A_CTRL, 32'(ctrl));
      store_doubleword_multiple(5'h02, 12'hFFC, -1);
    end
    wr(A_CLEAR, 32'h1F);
    rd(A_STATUS, 0);
    cmp(irq, 0);
    wr(A_ENABLE, 32'h1);
    rd(A_ENABLE, 32'h1);
    rd(8'h40, 0);
    run(1'b0, {16'h0, OP_LOGIC, 6'h2A, MIN_BRK});
    rd(A_STATUS, 32'h1);
    cmp(irq, 1);
    wr(A_ENABLE, 0);
    @(negedge clk);
    cmp(irq, 0);
    wr(A_ENABLE, 32'h1);
    @(negedge clk);
    cmp(irq, 1);
    wr(A_CLEAR, 32'h1);
    rd(A_STATUS, 0);
    cmp(irq, 0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(A_ENABLE, 32'h1);
    run(1'b0, {16'h0, OP_LOGIC, 6'h12, MIN_INV});
    rd(A_STATUS, 0);
    end_of_test();
  end
endmodule : compact_logic_store_exec_test
`default_nettype wire

// ### verif/store_partner.sv
// far-side store acknowledge model with latency and fault injection
`timescale 1ns/1ps
`default_nettype none
module store_partner (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        REQ_I,
  input  wire logic  [3:0] DELAY_I,
  input  wire logic [15:0] FAULT_AT_I,
  input  wire logic  [3:0] FCODE_I,
  output logic             ACK_O,
  output logic             FAULT_O,
  output logic       [3:0] CODE_O,
  output var logic  [15:0] N_O
);
  // ======
  // handshake
  logic [3:0] wait_r;
  logic       hit;
  assign hit     = REQ_I && (wait_r == DELAY_I);
  assign FAULT_O = hit && (N_O == FAULT_AT_I);
  assign ACK_O   = hit && !FAULT_O;
  // code only means something beside a fault, so show junk otherwise
  assign CODE_O  = FAULT_O ? FCODE_I : ~FCODE_I;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || !REQ_I || hit) wait_r <= 4'h0;
    else wait_r <= wait_r + 4'h1;
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) N_O <= 16'h0000;
    else if (hit) N_O <= N_O + 16'h0001;
  end
endmodule : store_partner
`default_nettype wire
